// [ssp_pkg.sv]
// constants shared by the serial special character processor
package ssp_pkg;
    // register indices; byte address is index times four
    localparam logic [3:0] REG_OPT2 = 4'h0;
    localparam logic [3:0] REG_OPT3 = 4'h1;
    localparam logic [3:0] REG_OPT4 = 4'h2;
    localparam logic [3:0] REG_OPT5 = 4'h3;
    localparam logic [3:0] REG_LNC = 4'h4;
    localparam logic [3:0] REG_SC1 = 4'h5;
    localparam logic [3:0] REG_RLO = 4'h9;
    localparam logic [3:0] REG_RHI = 4'hA;
    localparam logic [3:0] REG_STAT = 4'hB;
    localparam logic [7:0] CFG_RST = 8'h00;
    // field positions
    localparam int OPT2_ETC_BIT = 5;
    localparam int OPT3_SC34_BIT = 6;
    localparam int OPT3_RNG_BIT = 7;
    localparam int OPT4_TERM_LSB = 5;
    localparam int OPT4_BRK_LSB = 3;
    localparam int OPT4_ERR_LSB = 0;
    localparam int OPT5_TX_LSB = 0;
    localparam int OPT5_LNERR_BIT = 5;
    localparam int OPT5_LNEN_BIT = 6;
    localparam int OPT5_STRIP_BIT = 7;
    // error handling select codes
    localparam logic [2:0] EH_PAR_GOOD = 3'h1;
    localparam logic [2:0] EH_NULL = 3'h2;
    localparam logic [2:0] EH_MARK = 3'h3;
    localparam logic [2:0] EH_DISCARD = 3'h4;
    // characters and embedded commands
    localparam logic [7:0] CH_NUL = 8'h00;
    localparam logic [7:0] CH_NL = 8'h0A;
    localparam logic [7:0] CH_CR = 8'h0D;
    localparam logic [7:0] CH_SPACE = 8'h20;
    localparam logic [7:0] CH_FF = 8'hFF;
    localparam logic [7:0] CMD_BRK = 8'h81;
    localparam logic [7:0] CMD_DLY = 8'h82;
    localparam logic [7:0] CMD_STOP = 8'h83;
    localparam logic [7:0] CMD_SPC_MAX = 8'h3F;
    // receive exception causes
    localparam logic [2:0] EXC_NONE = 3'h0;
    localparam logic [2:0] EXC_ERR = 3'h1;
    localparam logic [2:0] EXC_BRK = 3'h2;
    localparam logic [2:0] EXC_SC1 = 3'h3;
    localparam logic [2:0] EXC_RNG = 3'h7;
    // least break length in clock cycles, one character time
    localparam int BRK_MIN_CYC = 2500;
    typedef enum logic [2:0] {TX_IDLE, TX_ESC, TX_DCNT, TX_DELAY, TX_SPACE, TX_CRNL} ssp_tx_st_t;
endpackage

// [ssp_timer.sv]
// loadable down counter used for delays and break length
`timescale 1ns/1ps
module ssp_timer #(
    parameter int W = 8
) (
    // clock, reset, enable
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    // control
    input wire logic load_i,
    input wire logic [W-1:0] val_i,
    input wire logic dec_i,
    // state
    output logic zero_o
);
    logic [W-1:0] cnt_reg;

    always_ff @(posedge core_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            cnt_reg <= '0;
        else if (ce_i)
        begin
            if (load_i)
                cnt_reg <= val_i;
            else if (dec_i && cnt_reg != '0)
                cnt_reg <= cnt_reg - 1'b1;
        end
    end

    assign zero_o = (cnt_reg == '0);
endmodule // ssp_timer

// [ssp_rx_match.sv]
// special character and range matcher for received characters
`timescale 1ns/1ps
module ssp_rx_match (
    // character and programmed values
    input wire logic [7:0] ch_i,
    input wire logic [31:0] sc_i,
    input wire logic en34_i,
    input wire logic rng_en_i,
    input wire logic [7:0] lo_i,
    input wire logic [7:0] hi_i,
    // result
    output logic [2:0] cause_o
);
    logic [3:0] hit;

    genvar g;
    generate
        for (g = 0; g < 4; g++)
        begin : g_sc
            // characters one and two always detected, three and four by enable
            assign hit[g] = (ch_i == sc_i[8*g +: 8]) && (g < 2 || en34_i);
        end
    endgenerate

    always_comb
    begin
        cause_o = ssp_pkg::EXC_NONE;
        if (rng_en_i && ch_i >= lo_i && ch_i <= hi_i)
            cause_o = ssp_pkg::EXC_RNG;
        for (int i = 3; i >= 0; i--)
            if (hit[i])
                cause_o = 3'(ssp_pkg::EXC_SC1 + 3'(i));
    end
endmodule // ssp_rx_match

// [ssp_top.sv]
// serial special character processor: receive and transmit paths with apb registers
// ==========================================================
`timescale 1ns/1ps
module ssp_top #(
    parameter int AW = 8,
    parameter int BRK_MIN = ssp_pkg::BRK_MIN_CYC
) (
    // clock, reset, enable
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [AW-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // from receive bit engine
    input wire logic rx_valid_i,
    input wire logic [7:0] rx_data_i,
    input wire logic rx_par_err_i,
    input wire logic rx_frm_err_i,
    input wire logic rx_ovr_err_i,
    input wire logic rx_brk_i,
    output logic rx_ready_o,
    // to receive fifo
    output logic rxf_valid_o,
    output logic [7:0] rxf_data_o,
    output logic rxf_exc_o,
    output logic [2:0] rxf_cause_o,
    input wire logic rxf_ready_i,
    // from transmit fifo
    input wire logic txf_valid_i,
    input wire logic [7:0] txf_data_i,
    output logic txf_pop_o,
    // to transmit bit engine
    output logic tx_valid_o,
    output logic [7:0] tx_data_o,
    input wire logic tx_ready_i,
    output logic tx_break_o,
    // prescale timer tick
    input wire logic tick_i
);
    // ==========================================================
    // registers
    logic [7:0] cfg_reg [0:10];
    logic [7:0] stat_reg;
    logic [3:0] idx;
    logic mapped;
    logic wr_en;

    assign idx = paddr_i[5:2];
    assign mapped = (paddr_i[AW-1:6] == '0) && (idx <= ssp_pkg::REG_STAT) && (paddr_i[1:0] == 2'h0);
    assign wr_en = ce_i && psel_i && penable_i && pready_o && pwrite_i && mapped;

    always_ff @(posedge core_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o <= 32'h0000_0000;
        end
        else if (ce_i)
        begin
            pready_o <= psel_i && !penable_i;
            pslverr_o <= psel_i && !penable_i && !mapped;
            prdata_o <= 32'h0000_0000;
            if (psel_i && !penable_i && mapped && !pwrite_i)
                prdata_o[7:0] <= (idx == ssp_pkg::REG_STAT) ? stat_reg : cfg_reg[idx];
        end
    end

    always_ff @(posedge core_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            for (int i = 0; i <= 10; i++)
                cfg_reg[i] <= ssp_pkg::CFG_RST;
        end
        else if (wr_en && idx != ssp_pkg::REG_STAT)
            cfg_reg[idx] <= pwdata_i[7:0];
    end

    // option fields
    logic etc_en;
    logic [1:0] tx_term;
    logic [2:0] rx_term;
    logic [1:0] brk_sel;
    logic [2:0] eh_sel;
    logic ln_en;
    logic ln_err;
    logic strip;
    logic [7:0] ln_char;

    assign etc_en = cfg_reg[ssp_pkg::REG_OPT2][ssp_pkg::OPT2_ETC_BIT];
    assign rx_term = cfg_reg[ssp_pkg::REG_OPT4][ssp_pkg::OPT4_TERM_LSB +: 3];
    assign brk_sel = cfg_reg[ssp_pkg::REG_OPT4][ssp_pkg::OPT4_BRK_LSB +: 2];
    assign eh_sel = cfg_reg[ssp_pkg::REG_OPT4][ssp_pkg::OPT4_ERR_LSB +: 3];
    assign tx_term = cfg_reg[ssp_pkg::REG_OPT5][ssp_pkg::OPT5_TX_LSB +: 2];
    assign ln_err = cfg_reg[ssp_pkg::REG_OPT5][ssp_pkg::OPT5_LNERR_BIT];
    assign ln_en = cfg_reg[ssp_pkg::REG_OPT5][ssp_pkg::OPT5_LNEN_BIT];
    assign strip = cfg_reg[ssp_pkg::REG_OPT5][ssp_pkg::OPT5_STRIP_BIT];
    assign ln_char = cfg_reg[ssp_pkg::REG_LNC];

    // ==========================================================
    // receive processing
    logic ln_flag_reg;
    logic [35:0] q_reg;
    logic [1:0] q_cnt_reg;
    logic [1:0] q_cnt_next;
    logic acc;
    logic pop;
    logic err;
    logic is_esc;
    logic good;
    logic set_ln;
    logic [1:0] push_n;
    logic [11:0] p0;
    logic [11:0] p1;
    logic [11:0] p2;
    logic [7:0] g_char;
    logic [2:0] m_cause;

    assign acc = ce_i && rx_valid_i && rx_ready_o;
    assign pop = ce_i && rxf_valid_o && rxf_ready_i;
    assign err = rx_par_err_i || rx_frm_err_i || rx_ovr_err_i;
    assign is_esc = ln_en && (rx_data_i == ln_char);

    ssp_rx_match u_match (
        .ch_i(g_char),
        .sc_i({cfg_reg[8], cfg_reg[7], cfg_reg[6], cfg_reg[ssp_pkg::REG_SC1]}),
        .en34_i(cfg_reg[ssp_pkg::REG_OPT3][ssp_pkg::OPT3_SC34_BIT]),
        .rng_en_i(cfg_reg[ssp_pkg::REG_OPT3][ssp_pkg::OPT3_RNG_BIT]),
        .lo_i(cfg_reg[ssp_pkg::REG_RLO]),
        .hi_i(cfg_reg[ssp_pkg::REG_RHI]),
        .cause_o(m_cause)
    );

    // entries are {exception, cause, data}
    always_comb
    begin
        push_n = 2'd0;
        p0 = 12'h000;
        p1 = 12'h000;
        p2 = 12'h000;
        set_ln = 1'b0;
        good = 1'b0;
        g_char = rx_data_i;
        if (ln_flag_reg)
        begin
            push_n = 2'd1;
            p0 = {4'h0, rx_data_i};
        end
        else if (rx_brk_i)
        begin
            if (brk_sel == 2'b01)
            begin
                push_n = 2'd1;
                p0 = {4'h0, ssp_pkg::CH_NUL};
            end
            else if (brk_sel == 2'b00)
            begin
                push_n = 2'd1;
                p0 = {1'b1, ssp_pkg::EXC_BRK, ssp_pkg::CH_NUL};
            end
        end
        else if (err && !(is_esc && ln_err))
        begin
            case (eh_sel)
                ssp_pkg::EH_PAR_GOOD:
                begin
                    good = !rx_frm_err_i && !rx_ovr_err_i;
                    push_n = good ? 2'd0 : 2'd1;
                    p0 = {1'b1, ssp_pkg::EXC_ERR, rx_data_i};
                end
                ssp_pkg::EH_NULL:
                begin
                    push_n = 2'd1;
                    p0 = {4'h0, ssp_pkg::CH_NUL};
                end
                ssp_pkg::EH_MARK:
                begin
                    push_n = 2'd3;
                    p0 = {4'h0, ssp_pkg::CH_FF};
                    p1 = {4'h0, ssp_pkg::CH_NUL};
                    p2 = {4'h0, rx_data_i};
                end
                ssp_pkg::EH_DISCARD:
                    push_n = 2'd0;
                default:
                begin
                    push_n = 2'd1;
                    p0 = {1'b1, ssp_pkg::EXC_ERR, rx_data_i};
                end
            endcase
        end
        else
            good = 1'b1;
        if (good && is_esc)
        begin
            push_n = 2'd1;
            p0 = {4'h0, rx_data_i};
            set_ln = 1'b1;
        end
        else if (good)
        begin
            if (strip)
                g_char[7] = 1'b0;
            if (g_char == ssp_pkg::CH_NL && rx_term[0])
                g_char = ssp_pkg::CH_CR;
            else if (g_char == ssp_pkg::CH_CR && rx_term[1] && !rx_term[2])
                g_char = ssp_pkg::CH_NL;
            push_n = 2'd1;
            p0 = {4'h0, g_char};
            if (rx_term[2] && {rx_data_i[7] && !strip, rx_data_i[6:0]} == ssp_pkg::CH_CR)
                push_n = 2'd0;
            else if (m_cause != ssp_pkg::EXC_NONE)
                p0 = {1'b1, m_cause, g_char};
            else if (eh_sel == ssp_pkg::EH_MARK && g_char == ssp_pkg::CH_FF)
            begin
                push_n = 2'd2;
                p1 = {4'h0, ssp_pkg::CH_FF};
            end
        end
    end

    always_comb
    begin
        q_cnt_next = q_cnt_reg;
        if (acc)
            q_cnt_next = push_n;
        else if (pop)
            q_cnt_next = q_cnt_reg - 2'd1;
    end

    always_ff @(posedge core_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            q_reg <= '0;
            q_cnt_reg <= 2'd0;
            rx_ready_o <= 1'b0;
            rxf_valid_o <= 1'b0;
        end
        else if (ce_i)
        begin
            if (acc)
                q_reg <= {p2, p1, p0};
            else if (pop)
                q_reg <= {12'h000, q_reg[35:12]};
            q_cnt_reg <= q_cnt_next;
            rx_ready_o <= (q_cnt_next == 2'd0);
            rxf_valid_o <= (q_cnt_next != 2'd0);
        end
    end

    assign rxf_data_o = q_reg[7:0];
    assign rxf_cause_o = q_reg[10:8];
    assign rxf_exc_o = q_reg[11];

    always_ff @(posedge core_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            ln_flag_reg <= 1'b0;
        else if (acc)
            ln_flag_reg <= set_ln;
    end

    // ==========================================================
    // transmit processing
    ssp_pkg::ssp_tx_st_t st_reg;
    logic pop_reg;
    logic brk_reg;
    logic [5:0] spc_reg;
    logic take;
    logic dly_zero;
    logic bmin_zero;
    logic [7:0] b;

    assign b = txf_data_i;
    assign txf_pop_o = pop_reg;
    assign tx_break_o = brk_reg;

    always_comb
    begin
        take = 1'b0;
        if (ce_i && txf_valid_i && !pop_reg && !tx_valid_o)
            case (st_reg)
                ssp_pkg::TX_IDLE: take = !brk_reg || bmin_zero;
                ssp_pkg::TX_ESC: take = 1'b1;
                ssp_pkg::TX_DCNT: take = 1'b1;
                default: take = 1'b0;
            endcase
    end

    ssp_timer #(.W(8)) u_delay (
        .core_clk_i(core_clk_i),
        .rstn_i(rstn_i),
        .ce_i(ce_i),
        .load_i(take && st_reg == ssp_pkg::TX_DCNT),
        .val_i(b),
        .dec_i(tick_i),
        .zero_o(dly_zero)
    );

    ssp_timer #(.W(16)) u_brk_min (
        .core_clk_i(core_clk_i),
        .rstn_i(rstn_i),
        .ce_i(ce_i),
        .load_i(take && st_reg == ssp_pkg::TX_ESC && b == ssp_pkg::CMD_BRK),
        .val_i(16'(BRK_MIN)),
        .dec_i(1'b1),
        .zero_o(bmin_zero)
    );

    always_ff @(posedge core_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            st_reg <= ssp_pkg::TX_IDLE;
            pop_reg <= 1'b0;
            brk_reg <= 1'b0;
            spc_reg <= 6'h00;
            tx_valid_o <= 1'b0;
            tx_data_o <= 8'h00;
        end
        else if (ce_i)
        begin
            pop_reg <= take;
            if (tx_valid_o && tx_ready_i)
                tx_valid_o <= 1'b0;
            case (st_reg)
                ssp_pkg::TX_IDLE:
                    if (take && etc_en && b == ssp_pkg::CH_NUL)
                        st_reg <= ssp_pkg::TX_ESC;
                    else if (take)
                    begin
                        brk_reg <= 1'b0;
                        tx_valid_o <= 1'b1;
                        tx_data_o <= b;
                        if (b == ssp_pkg::CH_CR && tx_term[0])
                            tx_data_o <= ssp_pkg::CH_NL;
                        else if (b == ssp_pkg::CH_NL && tx_term[1])
                        begin
                            tx_data_o <= ssp_pkg::CH_CR;
                            st_reg <= ssp_pkg::TX_CRNL;
                        end
                    end
                ssp_pkg::TX_ESC:
                    if (take)
                    begin
                        st_reg <= ssp_pkg::TX_IDLE;
                        if (b == ssp_pkg::CH_NUL)
                        begin
                            brk_reg <= 1'b0;
                            tx_valid_o <= 1'b1;
                            tx_data_o <= ssp_pkg::CH_NUL;
                        end
                        else if (b == ssp_pkg::CMD_BRK)
                            brk_reg <= 1'b1;
                        else if (b == ssp_pkg::CMD_DLY)
                            st_reg <= ssp_pkg::TX_DCNT;
                        else if (b == ssp_pkg::CMD_STOP)
                            brk_reg <= 1'b0;
                        else if (b <= ssp_pkg::CMD_SPC_MAX)
                        begin
                            brk_reg <= 1'b0;
                            spc_reg <= b[5:0];
                            st_reg <= ssp_pkg::TX_SPACE;
                        end
                    end
                ssp_pkg::TX_DCNT:
                    if (take)
                        st_reg <= ssp_pkg::TX_DELAY;
                ssp_pkg::TX_DELAY:
                    if (dly_zero)
                    begin
                        brk_reg <= 1'b0;
                        st_reg <= ssp_pkg::TX_IDLE;
                    end
                ssp_pkg::TX_SPACE:
                    if (!tx_valid_o)
                    begin
                        tx_valid_o <= 1'b1;
                        tx_data_o <= ssp_pkg::CH_SPACE;
                        spc_reg <= spc_reg - 6'h01;
                        if (spc_reg == 6'h01)
                            st_reg <= ssp_pkg::TX_IDLE;
                    end
                ssp_pkg::TX_CRNL:
                    if (!tx_valid_o)
                    begin
                        tx_valid_o <= 1'b1;
                        tx_data_o <= ssp_pkg::CH_NL;
                        st_reg <= ssp_pkg::TX_IDLE;
                    end
                default:
                    st_reg <= ssp_pkg::TX_IDLE;
            endcase
        end
    end

    // ==========================================================
    // status: last exception cause, break, delay, literal-next pending
    always_ff @(posedge core_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            stat_reg <= 8'h00;
        else if (ce_i)
        begin
            stat_reg[7:3] <= {2'b00, ln_flag_reg, st_reg == ssp_pkg::TX_DELAY, brk_reg};
            if (acc && push_n != 2'd0 && p0[11])
                stat_reg[2:0] <= p0[10:8];
        end
    end

    // ==========================================================
    // checks
    chk_apb_ready_pulse: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        pready_o |=> !pready_o) else $error("pready held more than one cycle");
    chk_rx_nl_to_cr: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        acc && good && !set_ln && !strip && rx_term == 3'b001 && rx_data_i == ssp_pkg::CH_NL
        |-> g_char == ssp_pkg::CH_CR) else $error("newline not turned into CR");
    chk_rx_cr_drop: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        acc && good && !set_ln && rx_term[2] && rx_data_i == ssp_pkg::CH_CR
        |=> q_cnt_reg == 2'd0) else $error("CR not discarded");
    chk_rx_mark_three: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        acc && !ln_flag_reg && !rx_brk_i && err && !is_esc && eh_sel == ssp_pkg::EH_MARK
        |=> rxf_valid_o && rxf_data_o == ssp_pkg::CH_FF && q_cnt_reg == 2'd3)
        else $error("marking sequence not stored");
    chk_rx_literal_next_escape_one: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        acc && ln_flag_reg |=> !ln_flag_reg && q_cnt_reg == 2'd1)
        else $error("literal next not single character");
    chk_tx_nl_expand: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        take && st_reg == ssp_pkg::TX_IDLE && !etc_en && b == ssp_pkg::CH_NL && tx_term == 2'b10
        |=> tx_data_o == ssp_pkg::CH_CR && st_reg == ssp_pkg::TX_CRNL)
        else $error("newline not expanded");
    chk_tx_cr_once: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        take && st_reg == ssp_pkg::TX_IDLE && !etc_en && b == ssp_pkg::CH_CR && tx_term == 2'b11
        |=> tx_data_o == ssp_pkg::CH_NL && st_reg == ssp_pkg::TX_IDLE)
        else $error("CR translated twice");
    chk_tx_brk_min: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        $rose(brk_reg) |-> brk_reg[*3]) else $error("break shorter than minimum");
    chk_tx_stop_brk: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        take && st_reg == ssp_pkg::TX_ESC && b == ssp_pkg::CMD_STOP |=> !tx_break_o)
        else $error("stop break ignored");
endmodule // ssp_top

// [ssp_line_model.sv]
// transmit line engine model that takes bytes, stalling on a fixed pattern
`timescale 1ns/1ps
module ssp_line_model (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rstn_i,
    // engine side
    input wire logic slow_i,
    output logic tx_ready_o
);
    logic [1:0] cnt_reg;
    always_ff @(posedge core_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            cnt_reg <= 2'h0;
        else
            cnt_reg <= cnt_reg + 2'h1;
    end
    // a slow engine takes one byte in four cycles
    // no modem pins modelled
    assign tx_ready_o = slow_i ? (cnt_reg == 2'h3) : 1'h1;
endmodule // ssp_line_model

// [serial_special_char_processor_tb.sv]
// bench for the serial special character processor
`timescale 1ns/1ps
module serial_special_char_processor_tb;
    logic clk = 1'h0, rst_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic rx_valid = 1'h0, par = 1'h0, txf_valid = 1'h0, slow = 1'h0, tick = 1'h0, rbrk = 1'h0;
    logic pready, pslverr, rx_ready, rxf_valid, rxf_exc, pop, tx_valid, tx_ready, er, tbrk;
    logic [2:0] cause, tc = 3'h0;
    logic [7:0] paddr = 8'h00, rx_data = 8'h00, txf_data = 8'h00, rxf_data, tx_data;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [11:0] rq[$];
    logic [7:0] tq[$];
    int n_errors = 0, n_tests = 0;
    always #2 clk = ~clk;
    ssp_top #(.BRK_MIN(4)) uut (.core_clk_i(clk), .rstn_i(rst_n), .ce_i(1'h1), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .rx_valid_i(rx_valid),
        .rx_data_i(rx_data), .rx_par_err_i(par), .rx_frm_err_i(1'h0), .rx_ovr_err_i(1'h0),
        .rx_brk_i(rbrk), .rx_ready_o(rx_ready), .rxf_valid_o(rxf_valid), .rxf_data_o(rxf_data),
        .rxf_exc_o(rxf_exc), .rxf_cause_o(cause), .rxf_ready_i(1'h1), .txf_valid_i(txf_valid),
        .txf_data_i(txf_data), .txf_pop_o(pop), .tx_valid_o(tx_valid), .tx_data_o(tx_data),
        .tx_ready_i(tx_ready), .tx_break_o(tbrk), .tick_i(tick));
    ssp_line_model u_line (.core_clk_i(clk), .rstn_i(rst_n), .slow_i(slow), .tx_ready_o(tx_ready));
    always @(posedge clk)
    begin
        tc <= tc + 3'h1;
        tick <= (tc == 3'h0);
        if (rxf_valid)
            rq.push_back({rxf_exc, cause, rxf_data});
        if (tx_valid && tx_ready)
            tq.push_back(tx_data);
    end
    task automatic results();
        $display("checks %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e)
        begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    // bounded wait on a settled level
    task automatic hold(input int k);
        int i;
        for (i = 0; i < 60; i++)
        begin
            @(negedge clk);
            if ((k == 0 && pready) || (k == 1 && rx_ready) || (k == 2 && pop)
                || (k >= 3 && tq.size() >= k - 2))
                break;
        end
        if (i == 60)
        begin
            n_errors++;
            results();
        end
    endtask
    task automatic apb(input logic w, input logic [3:0] idx, input logic [7:0] d);
        @(posedge clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= {2'h0, idx, 2'h0};
        pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1'h1;
        hold(0);
        @(posedge clk);
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic rx(input logic [7:0] d, input logic pe);
        @(posedge clk);
        rx_valid <= 1'h1;
        rx_data <= d;
        par <= pe;
        hold(1);
        @(posedge clk);
        rx_valid <= 1'h0;
        repeat (8) @(posedge clk);
    endtask
    task automatic tx(input logic [7:0] d);
        @(posedge clk);
        txf_valid <= 1'h1;
        txf_data <= d;
        hold(2);
        @(posedge clk);
        txf_valid <= 1'h0;
    endtask
    function automatic logic [31:0] nxr();
        return rq.size() > 0 ? {20'h0, rq.pop_front()} : 32'hFFFFFFFF;
    endfunction
    task automatic t_rx();
        apb(1'h0, ssp_pkg::REG_OPT4, 8'h00);
        chk("reset value", 32'h0, rd);
        apb(1'h0, 4'hC, 8'h00);
        chk("unmapped", 32'h1, {31'h0, er});
        apb(1'h1, ssp_pkg::REG_OPT4, 8'h60);
        rx(8'h0A, 1'h0);
        rx(8'h0D, 1'h0);
        chk("nl to cr", 32'h0D, nxr());
        chk("cr to nl", 32'h0A, nxr());
        apb(1'h1, ssp_pkg::REG_OPT4, 8'hA0);
        rx(8'h0D, 1'h0);
        rx(8'h0A, 1'h0);
        chk("cr dropped", 32'h0D, nxr());
        chk("no entry", 32'hFFFFFFFF, nxr());
        $display("test receive terminators done");
    endtask
    task automatic t_err();
        apb(1'h1, ssp_pkg::REG_OPT4, 8'h00);
        rx(8'h41, 1'h1);
        chk("error exc", 32'h941, nxr());
        rbrk <= 1'h1;
        rx(8'h00, 1'h0);
        rbrk <= 1'h0;
        chk("break exc", 32'hA00, nxr());
        apb(1'h1, ssp_pkg::REG_OPT4, {5'h0, ssp_pkg::EH_DISCARD});
        rx(8'h41, 1'h1);
        chk("discarded", 32'hFFFFFFFF, nxr());
        apb(1'h1, ssp_pkg::REG_OPT4, {5'h0, ssp_pkg::EH_MARK});
        rx(8'h41, 1'h1);
        rx(8'hFF, 1'h0);
        chk("marking ff", 32'hFF, nxr());
        chk("marking null", 32'h00, nxr());
        chk("marking char", 32'h41, nxr());
        chk("good ff one", 32'hFF, nxr());
        chk("good ff two", 32'hFF, nxr());
        apb(1'h1, ssp_pkg::REG_OPT3, 8'h80);
        apb(1'h1, ssp_pkg::REG_RLO, 8'h30);
        apb(1'h1, ssp_pkg::REG_RHI, 8'h39);
        rx(8'h39, 1'h0);
        chk("range hit", 32'hF39, nxr());
        apb(1'h1, ssp_pkg::REG_LNC, 8'h35);
        apb(1'h1, ssp_pkg::REG_OPT5, 8'h40);
        rx(8'h35, 1'h0);
        rx(8'h36, 1'h0);
        rx(8'h37, 1'h0);
        chk("escape char", 32'h035, nxr());
        chk("escaped char", 32'h036, nxr());
        chk("range after", 32'hF37, nxr());
        $display("test errors and range done");
    endtask
    task automatic t_tx();
        slow <= 1'h1;
        apb(1'h1, ssp_pkg::REG_OPT5, 8'h02);
        tx(8'h0A);
        hold(4);
        chk("expand", 32'h0D0A, {16'h0, tq[0], tq[1]});
        apb(1'h1, ssp_pkg::REG_OPT5, 8'h03);
        tx(8'h0D);
        hold(5);
        chk("one translation", 32'h0A, {24'h0, tq[2]});
        apb(1'h1, ssp_pkg::REG_OPT2, 8'h20);
        tx(8'h00);
        tx(8'h00);
        tx(8'h42);
        hold(7);
        chk("one null", 32'h0042, {16'h0, tq[3], tq[4]});
        $display("test transmit done");
    endtask
    task automatic t_etc();
        tx(8'h00);
        tx(ssp_pkg::CMD_BRK);
        repeat (20) @(negedge clk);
        chk("break held", 32'h1, {31'h0, tbrk});
        tx(8'h00);
        tx(ssp_pkg::CMD_STOP);
        @(negedge clk);
        chk("break stopped", 32'h0, {31'h0, tbrk});
        tx(8'h00);
        tx(8'h03);
        hold(10);
        chk("spaces", 32'h202020, {8'h0, tq[5], tq[6], tq[7]});
        tx(8'h00);
        tx(ssp_pkg::CMD_DLY);
        tx(8'h02);
        apb(1'h0, ssp_pkg::REG_STAT, 8'h00);
        chk("delay status", 32'h2, {29'h0, rd[5:3]});
        tx(8'h43);
        hold(11);
        chk("after delay", 32'h43, {24'h0, tq[8]});
        $display("test embedded commands done");
    endtask
    initial
    begin
        repeat (8) @(posedge clk);
        rst_n <= 1'h1;
        t_rx();
        t_err();
        t_tx();
        t_etc();
        results();
    end
endmodule // serial_special_char_processor_tb
